/* File: pms_defs.svh */
/*
  Constants for the preset memory sequencer: register indices, field ranges,
  command codes, location numbers and timing.
  Assumes a 100 MHz clock and a Wishbone bus with 32-bit data.
*/
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

`define PMS_IX_CMD        3'h0
`define PMS_IX_CTRL       3'h1
`define PMS_IX_STAT       3'h2
`define PMS_IX_DIV        3'h3

`define PMS_F_OP          3:0
`define PMS_F_ARG         10:4
`define PMS_B_LOCK        0
`define PMS_B_HOLD_UP     1
`define PMS_B_HOLD_DN     2

`define PMS_C_STORE       4'h1
`define PMS_C_RECALL      4'h2
`define PMS_C_SEQ_UP      4'h3
`define PMS_C_SEQ_DN      4'h4
`define PMS_C_PSTORE      4'h5
`define PMS_C_PRECALL     4'h6
`define PMS_C_RESET_FP    4'h7
`define PMS_C_RESET_RMT   4'h8
`define PMS_C_KEY_STORE   4'h9
`define PMS_C_KEY_OTHER   4'hA
`define PMS_C_DIV_SHOW    4'hB
`define PMS_C_DIV_DIGIT   4'hC
`define PMS_C_DIV_SKIP    4'hD

`define PMS_OP_SAVE       3'h0
`define PMS_OP_LOAD       3'h1
`define PMS_OP_COPY       3'h2
`define PMS_OP_PSAVE      3'h3
`define PMS_OP_PLOAD      3'h4

`define PMS_LOC_SCRATCH   7'h00
`define PMS_LOC_MIN       7'h01
`define PMS_LOC_MAX       7'h32
`define PMS_LOC_PARAM     7'h60
`define PMS_LOC_DFLT      7'h61
`define PMS_LOC_CUR       7'h63
`define PMS_REL_PARAMS    4'h2
`define PMS_RADIX         7'h0A
`define PMS_TENS_MAX      4'h5
`define PMS_DIGIT_MAX     4'h9
`define PMS_NDIV          4
`define PMS_DIV_W         6

`define PMS_CLK_MHZ       100
`define PMS_CONFIRM_MS    5000
`define PMS_SHOW_MS       5000
`define PMS_REPEAT_MS     200
`define PMS_CONFIRM_CYC   (`PMS_CONFIRM_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_SHOW_CYC      (`PMS_SHOW_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_REPEAT_CYC    (`PMS_REPEAT_MS * 1000 * `PMS_CLK_MHZ)

`endif

/* File: pms_nv_model.sv */
/*
  State-memory controller model: answers each request lat+1 cycles after nv_req rises.
  Assumes the requester drops nv_req at the edge that samples nv_ack.
*/
`timescale 1ns/1ps
module pms_nv_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       nv_req,
  input  wire logic [1:0] lat,
  output logic            nv_ack
);
  logic [1:0] wait_r;
  // Slow answers keep the sequencer busy longer, as a real memory would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_ack <= 1'b0;
      wait_r <= 2'h0;
    end else if (nv_ack || !nv_req) begin
      nv_ack <= 1'b0;
      wait_r <= 2'h0;
    end else if (wait_r == lat) begin
      nv_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule : pms_nv_model

/* File: pms_pkg.sv */
/*
  Types for the preset memory sequencer.
  Assumes nothing beyond the sequencer module that uses them.
*/
package pms_pkg;
  typedef enum logic [1:0] {PMS_IDLE, PMS_OP, PMS_FILL} pms_state_e;
  typedef logic [6:0] pms_loc_t;
  typedef logic [23:0] pms_divs_t;
endpackage : pms_pkg

/* File: pms_sequencer.sv */
/*
  Preset memory sequencer: partition-bounded stepping, divider entry, write lock, memory reset and
  single-parameter store/recall. Assumes a same-clock Wishbone master and a one-cycle nv_ack per nv_req.
*/
// Summary of operation
// - Sequence requests ignored while sweep active
// - Sequence up recalls next location, wraps
// - Held key keeps stepping and recalling, up or down
// - Sequence down steps below, wraps to top
// - No dividers: range covers 01 to 50
// - Dividers bound wrapping within each partition
// - Divider location belongs to upper partition
// - Four dividers, 01 and 50 outer bounds
// - Show dividers; digit then starts entry
// - Commit only after four; other key aborts
// - Skip keeps old value if no digit
// - Value 00 deletes the divider
// - Sort, commit, show for five seconds
// - Out-of-range divider digits abort entry at once
// - Duplicates accepted, removed when sorting
// - Lock rejects stores to 01-50 and 96
// - Memory reset copies 97 into user, 96, 99
// - Panel reset needs store within 5 seconds
// - Timeout or other key abandons the reset
// - Remote reset acts at once
// - Single parameter store/recall uses location 96
// - Location 96 default until parameter stored
// - Frequency/amplitude carry relative flag, offset, reference
// - Recall never changes output on/off
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_sequencer #(
  parameter int unsigned CONFIRM_CYC = `PMS_CONFIRM_CYC,
  parameter int unsigned SHOW_CYC    = `PMS_SHOW_CYC,
  parameter int unsigned REPEAT_CYC  = `PMS_REPEAT_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sweep_active,
  output logic             nv_req,
  output logic      [2:0]  nv_op,
  output logic      [6:0]  nv_src,
  output logic      [6:0]  nv_dst,
  output logic      [3:0]  nv_param,
  output logic             nv_rel,
  input  wire logic        nv_ack
);
  pms_pkg::pms_state_e state_r;
  pms_pkg::pms_loc_t   last_r, pend_r, fill_r, seq_loc, go_src, go_dst, carg, dval;
  pms_pkg::pms_divs_t  div_r, new_r, new_nxt, wdiv;
  logic [2:0]  swp_r, go_op;
  logic        sweep_r, lock_r, hold_up_r, hold_dn_r, p96_used_r, upd_r;
  logic        op_rej_r, ent_rej_r, prompt_r, show_r, entry_r, part_r;
  logic [1:0]  eidx_r;
  logic [3:0]  pdig_r, cop;
  logic [31:0] rpt_r, pcnt_r, scnt_r;
  logic        wr, cmd_v, step_ok, busy, go, go_upd, fill_go, bad, div_ok;
  // Dedupe then ascending sort; deleted dividers (00) sink to the front
  function automatic pms_pkg::pms_divs_t div_sort(input pms_pkg::pms_divs_t v);
    logic [5:0] t, a [4];
    for (int i = 0; i < `PMS_NDIV; i++) a[i] = v[i*`PMS_DIV_W +: `PMS_DIV_W];
    for (int i = 1; i < `PMS_NDIV; i++)
      for (int j = 0; j < i; j++)
        if (a[i] == a[j]) a[i] = '0;
    for (int i = 0; i < `PMS_NDIV - 1; i++)
      for (int j = 0; j < `PMS_NDIV - 1 - i; j++)
        if (a[j] > a[j+1]) begin
          t = a[j];
          a[j] = a[j+1];
          a[j+1] = t;
        end
    return {a[3], a[2], a[1], a[0]};
  endfunction : div_sort
  // Partition bounds from the active dividers around the current location
  function automatic pms_pkg::pms_loc_t seq_next(input pms_pkg::pms_loc_t cur,
                                                 input pms_pkg::pms_divs_t dv, input logic up);
    pms_pkg::pms_loc_t lo, hi, d;
    lo = `PMS_LOC_MIN;
    hi = `PMS_LOC_MAX;
    for (int i = 0; i < `PMS_NDIV; i++) begin
      d = {1'b0, dv[i*`PMS_DIV_W +: `PMS_DIV_W]};
      if (d != `PMS_LOC_SCRATCH) begin
        if (d <= cur && d > lo) lo = d;
        if (d > cur && d - `PMS_LOC_MIN < hi) hi = d - `PMS_LOC_MIN;
      end
    end
    if (cur < `PMS_LOC_MIN || cur > `PMS_LOC_MAX) return up ? `PMS_LOC_MIN : `PMS_LOC_MAX;
    if (up) return (cur >= hi) ? lo : cur + `PMS_LOC_MIN;
    return (cur <= lo) ? hi : cur - `PMS_LOC_MIN;
  endfunction : seq_next
  // Three-stage synchroniser; a change counts once the last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swp_r   <= '0;
      sweep_r <= 1'b0;
    end else begin
      swp_r <= {swp_r[1:0], sweep_active};
      if (swp_r[2] == swp_r[1]) sweep_r <= swp_r[2];
    end
  end
  // Bus slave: ack one cycle after the request, writes act on the ack edge
  assign wr    = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
  assign cmd_v = wr && wb_adr_i == `PMS_IX_CMD && wb_sel_i[1:0] == 2'h3;
  assign cop   = wb_dat_i[`PMS_F_OP];
  assign carg  = wb_dat_i[`PMS_F_ARG];
  assign busy  = state_r != pms_pkg::PMS_IDLE;
  assign wdiv  = {wb_dat_i[29:24], wb_dat_i[21:16], wb_dat_i[13:8], wb_dat_i[5:0]};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      unique case (wb_adr_i)
        `PMS_IX_CTRL: wb_dat_o <= {29'h0, hold_dn_r, hold_up_r, lock_r};
        `PMS_IX_STAT: wb_dat_o <= {16'h0, sweep_r, ent_rej_r | op_rej_r, show_r, part_r, eidx_r,
                                   entry_r, prompt_r, busy, last_r};
        `PMS_IX_DIV:  wb_dat_o <= {2'h0, div_r[23:18], 2'h0, div_r[17:12], 2'h0, div_r[11:6], 2'h0, div_r[5:0]};
        default:      wb_dat_o <= '0;
      endcase
    end
  end
  // Lock and held keys live here, never in a stored state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_r    <= 1'b0;
      hold_up_r <= 1'b0;
      hold_dn_r <= 1'b0;
    end else if (wr && wb_adr_i == `PMS_IX_CTRL && wb_sel_i[0]) begin
      lock_r    <= wb_dat_i[`PMS_B_LOCK];
      hold_up_r <= wb_dat_i[`PMS_B_HOLD_UP];
      hold_dn_r <= wb_dat_i[`PMS_B_HOLD_DN];
    end
  end
  // Key repeat: first step at once, then one per repeat period while held
  assign step_ok = (hold_up_r | hold_dn_r) && rpt_r == '0 && !busy && !sweep_r && !prompt_r && !entry_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rpt_r <= '0;
    else if (!hold_up_r && !hold_dn_r) rpt_r <= '0;
    else if (step_ok) rpt_r <= REPEAT_CYC - 1;
    else if (rpt_r != '0) rpt_r <= rpt_r - 1;
  end
  assign seq_loc = seq_next(last_r, div_r, cmd_v ? cop == `PMS_C_SEQ_UP : hold_up_r);
  // Command decode for state-memory operations
  always_comb begin
    go      = 1'b0;
    go_upd  = 1'b1;
    go_op   = `PMS_OP_LOAD;
    go_src  = carg;
    go_dst  = `PMS_LOC_CUR;
    fill_go = 1'b0;
    bad     = 1'b0;
    if (cmd_v && !prompt_r && !entry_r) begin
      unique case (cop)
        `PMS_C_STORE: begin
          if (busy || sweep_r || lock_r || carg < `PMS_LOC_MIN || carg > `PMS_LOC_MAX) bad = 1'b1;
          else go = 1'b1;
          go_op  = `PMS_OP_SAVE;
          go_src = `PMS_LOC_CUR;
          go_dst = carg;
        end
        `PMS_C_RECALL: begin
          if (busy || sweep_r || (carg > `PMS_LOC_MAX && carg < `PMS_LOC_PARAM)) bad = 1'b1;
          else go = 1'b1;
        end
        `PMS_C_SEQ_UP, `PMS_C_SEQ_DN: begin
          if (busy || sweep_r) bad = 1'b1;
          else go = 1'b1;
          go_src = seq_loc;
        end
        `PMS_C_PSTORE: begin
          if (busy || sweep_r || lock_r) bad = 1'b1;
          else go = 1'b1;
          go_op  = `PMS_OP_PSAVE;
          go_src = `PMS_LOC_CUR;
          go_dst = `PMS_LOC_PARAM;
          go_upd = 1'b0;
        end
        `PMS_C_PRECALL: begin
          if (busy || sweep_r) bad = 1'b1;
          else go = 1'b1;
          go_op  = `PMS_OP_PLOAD;
          go_src = p96_used_r ? `PMS_LOC_PARAM : `PMS_LOC_DFLT;
          go_upd = 1'b0;
        end
        `PMS_C_RESET_RMT: begin
          if (busy) bad = 1'b1;
          else fill_go = 1'b1;
        end
        default: ;
      endcase
    end else if (cmd_v && prompt_r && cop == `PMS_C_KEY_STORE) begin
      if (busy) bad = 1'b1;
      else fill_go = 1'b1;
    end else if (step_ok) begin
      go     = 1'b1;
      go_src = seq_loc;
    end
  end
  // State-memory sequencer: one request at a time, level until nv_ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= pms_pkg::PMS_IDLE;
      nv_req     <= 1'b0;
      nv_op      <= `PMS_OP_LOAD;
      nv_src     <= `PMS_LOC_SCRATCH;
      nv_dst     <= `PMS_LOC_SCRATCH;
      nv_param   <= '0;
      nv_rel     <= 1'b0;
      last_r     <= `PMS_LOC_SCRATCH;
      pend_r     <= `PMS_LOC_SCRATCH;
      upd_r      <= 1'b0;
      fill_r     <= `PMS_LOC_MIN;
      p96_used_r <= 1'b0;
      op_rej_r   <= 1'b0;
    end else begin
      if (bad) op_rej_r <= 1'b1;
      else if (go || fill_go) op_rej_r <= 1'b0;
      unique case (state_r)
        pms_pkg::PMS_IDLE: begin
          if (go) begin
            state_r  <= pms_pkg::PMS_OP;
            nv_req   <= 1'b1;
            nv_op    <= go_op;
            nv_src   <= go_src;
            nv_dst   <= go_dst;
            nv_param <= carg[3:0];
            nv_rel   <= carg[3:0] < `PMS_REL_PARAMS;
            pend_r   <= (go_op == `PMS_OP_SAVE) ? go_dst : go_src;
            upd_r    <= go_upd;
          end else if (fill_go) begin
            state_r <= pms_pkg::PMS_FILL;
            nv_req  <= 1'b1;
            nv_op   <= `PMS_OP_COPY;
            nv_src  <= `PMS_LOC_DFLT;
            nv_dst  <= `PMS_LOC_MIN;
            fill_r  <= `PMS_LOC_MIN;
          end
        end
        pms_pkg::PMS_OP: begin
          if (nv_ack) begin
            nv_req  <= 1'b0;
            state_r <= pms_pkg::PMS_IDLE;
            if (upd_r) last_r <= pend_r;
            if (nv_op == `PMS_OP_PSAVE) p96_used_r <= 1'b1;
          end
        end
        pms_pkg::PMS_FILL: begin
          if (nv_req && nv_ack) begin
            nv_req <= 1'b0;
            if (fill_r == `PMS_LOC_CUR) begin
              state_r    <= pms_pkg::PMS_IDLE;
              p96_used_r <= 1'b0;
            end else if (fill_r == `PMS_LOC_MAX) fill_r <= `PMS_LOC_PARAM;
            else if (fill_r == `PMS_LOC_PARAM) fill_r <= `PMS_LOC_CUR;
            else fill_r <= fill_r + `PMS_LOC_MIN;
          end else if (!nv_req) begin
            nv_req <= 1'b1;
            nv_dst <= fill_r;
          end
        end
      endcase
    end
  end
  // Confirm window for a panel-started memory reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prompt_r <= 1'b0;
      pcnt_r   <= '0;
    end else if (prompt_r) begin
      if (cmd_v) prompt_r <= 1'b0;
      else if (pcnt_r == '0) prompt_r <= 1'b0;
      else pcnt_r <= pcnt_r - 1;
    end else if (cmd_v && !entry_r && cop == `PMS_C_RESET_FP) begin
      prompt_r <= 1'b1;
      pcnt_r   <= CONFIRM_CYC - 1;
    end
  end
  // Divider entry: pending digit joined with the second one
  assign dval   = {3'h0, pdig_r} * `PMS_RADIX + {3'h0, carg[3:0]};
  assign div_ok = wdiv[5:0] <= `PMS_LOC_MAX && wdiv[11:6] <= `PMS_LOC_MAX &&
                  wdiv[17:12] <= `PMS_LOC_MAX && wdiv[23:18] <= `PMS_LOC_MAX;
  always_comb begin
    new_nxt = new_r;
    new_nxt[eidx_r*`PMS_DIV_W +: `PMS_DIV_W] = dval[5:0];
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r     <= '0;
      new_r     <= '0;
      entry_r   <= 1'b0;
      show_r    <= 1'b0;
      part_r    <= 1'b0;
      eidx_r    <= '0;
      pdig_r    <= '0;
      scnt_r    <= '0;
      ent_rej_r <= 1'b0;
    end else if (entry_r && cmd_v) begin
      if (cop == `PMS_C_DIV_DIGIT && !part_r) begin
        if (carg[3:0] > `PMS_TENS_MAX) begin
          entry_r   <= 1'b0;
          ent_rej_r <= 1'b1;
        end else begin
          part_r <= 1'b1;
          pdig_r <= carg[3:0];
        end
      end else if (cop == `PMS_C_DIV_DIGIT) begin
        if (carg[3:0] > `PMS_DIGIT_MAX || dval > `PMS_LOC_MAX) begin
          entry_r   <= 1'b0;
          part_r    <= 1'b0;
          ent_rej_r <= 1'b1;
        end else if (eidx_r == 2'h3) begin
          div_r   <= div_sort(new_nxt);
          entry_r <= 1'b0;
          part_r  <= 1'b0;
          show_r  <= 1'b1;
          scnt_r  <= SHOW_CYC - 1;
        end else begin
          new_r  <= new_nxt;
          eidx_r <= eidx_r + 2'h1;
          part_r <= 1'b0;
        end
      end else if (cop == `PMS_C_DIV_SKIP) begin
        if (!part_r && eidx_r == 2'h3) begin
          div_r   <= div_sort(new_r);
          entry_r <= 1'b0;
          show_r  <= 1'b1;
          scnt_r  <= SHOW_CYC - 1;
        end else if (!part_r) eidx_r <= eidx_r + 2'h1;
      end else begin
        entry_r <= 1'b0;
        part_r  <= 1'b0;
      end
    end else if (cmd_v && !prompt_r) begin
      ent_rej_r <= 1'b0;
      if (show_r && cop == `PMS_C_DIV_DIGIT) begin
        show_r <= 1'b0;
        new_r  <= div_r;
        eidx_r <= '0;
        pdig_r <= carg[3:0];
        if (carg[3:0] > `PMS_TENS_MAX) ent_rej_r <= 1'b1;
        else begin
          entry_r <= 1'b1;
          part_r  <= 1'b1;
        end
      end else if (cop == `PMS_C_DIV_SHOW) begin
        show_r <= 1'b1;
        scnt_r <= SHOW_CYC - 1;
      end else show_r <= 1'b0;
    end else if (wr && wb_adr_i == `PMS_IX_DIV && wb_sel_i == 4'hF && !entry_r) begin
      if (div_ok) div_r <= div_sort(wdiv);
      ent_rej_r <= !div_ok;
    end else if (show_r) begin
      if (scnt_r == '0) show_r <= 1'b0;
      else scnt_r <= scnt_r - 1;
    end
  end
endmodule : pms_sequencer

/* File: pms_sequencer_assertions.sv */
/*
  Port checker for pms_sequencer, bound into every instance.
  Assumes one clock and rst asynchronous, active high.
*/
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_sequencer_assertions #(
  parameter int unsigned CONFIRM_CYC = 20,
  parameter int unsigned SHOW_CYC    = 20,
  parameter int unsigned REPEAT_CYC  = 8
)(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:2]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sweep_active,
  input wire logic        nv_req,
  input wire logic [2:0]  nv_op,
  input wire logic [6:0]  nv_src,
  input wire logic [6:0]  nv_dst,
  input wire logic [3:0]  nv_param,
  input wire logic        nv_rel,
  input wire logic        nv_ack
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic lock_r;
  logic cmd_w;
  logic hit;
  assign hit   = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign cmd_w = hit && wb_adr_i == `PMS_IX_CMD && wb_sel_i[1:0] == 2'h3;
  // Lock mirror changes at the edge where the write lands, as the design's does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_r <= 1'b0;
    end else if (hit && wb_adr_i == `PMS_IX_CTRL && wb_sel_i[0]) begin
      lock_r <= wb_dat_i[`PMS_B_LOCK];
    end
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_nv_stable: assert property (nv_req && !nv_ack |=> nv_req && $stable(nv_op) && $stable(nv_src)
    && $stable(nv_dst) && $stable(nv_param)) else $error("request changed while pending");
  a_nv_drop: assert property (nv_req && nv_ack |=> !nv_req) else $error("request not dropped");
  a_sweep_block: assert property (
    sweep_active[*6] ##0 (cmd_w && (wb_dat_i[3:0] == `PMS_C_SEQ_UP || wb_dat_i[3:0] == `PMS_C_SEQ_DN))
    |=> !$rose(nv_req)) else $error("step during sweep");
  a_lock_block: assert property (
    lock_r && cmd_w && (wb_dat_i[3:0] == `PMS_C_STORE || wb_dat_i[3:0] == `PMS_C_PSTORE)
    |=> !$rose(nv_req)) else $error("store while locked");
  a_fill_source: assert property (
    $rose(nv_req) && nv_op == `PMS_OP_COPY |-> nv_src == `PMS_LOC_DFLT
    && (nv_dst inside {[7'h01:7'h32], 7'h60, 7'h63})) else $error("bad fill copy");
  a_fill_next: assert property (
    nv_req && nv_ack && nv_op == `PMS_OP_COPY && nv_dst < 7'h32
    |=> !nv_req ##1 nv_req && nv_dst == $past(nv_dst, 2) + 7'h01) else $error("fill order wrong");
  a_param_rel: assert property (
    nv_req && (nv_op == `PMS_OP_PSAVE || nv_op == `PMS_OP_PLOAD) |-> nv_rel == (nv_param < 4'h2))
    else $error("relative flag wrong");
  a_load_current: assert property (nv_req && nv_op == `PMS_OP_LOAD |-> nv_dst == 7'h63)
    else $error("load target wrong");
endmodule : pms_sequencer_assertions

bind pms_sequencer pms_sequencer_assertions #(.CONFIRM_CYC(CONFIRM_CYC), .SHOW_CYC(SHOW_CYC),
  .REPEAT_CYC(REPEAT_CYC)) u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sweep_active(sweep_active), .nv_req(nv_req), .nv_op(nv_op), .nv_src(nv_src),
  .nv_dst(nv_dst), .nv_param(nv_param), .nv_rel(nv_rel), .nv_ack(nv_ack));

/* File: pms_sequencer_test.sv */
/*
  Self-checking bench for pms_sequencer with a state-memory model.
  Assumes short sim counts: confirm 20, show 20, repeat 8 cycles.
*/
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_sequencer_test;
  logic        clk;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [4:2]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sweep_active;
  logic        nv_req;
  logic [2:0]  nv_op;
  logic [6:0]  nv_src;
  logic [6:0]  nv_dst;
  logic [3:0]  nv_param;
  logic        nv_rel;
  logic        nv_ack;
  logic [1:0]  lat;
  logic [15:0] st;
  logic [63:0] re;
  logic [43:0] ne;
  logic [43:0] exp_nv [$];
  logic [63:0] exp_rd [$];
  int          n_fail;
  int          check_count;
  int          nv_seen;
  logic [6:0]  pa [5] = '{7'h0D, 7'h07, 7'h0E, 7'h06, 7'h32};
  logic [6:0]  pe [5] = '{7'h07, 7'h0D, 7'h32, 7'h01, 7'h0E};
  logic [4:0]  pu = 5'h19;
  pms_sequencer #(.CONFIRM_CYC(20), .SHOW_CYC(20), .REPEAT_CYC(8)) dut (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sweep_active(sweep_active),
    .nv_req(nv_req), .nv_op(nv_op), .nv_src(nv_src), .nv_dst(nv_dst), .nv_param(nv_param),
    .nv_rel(nv_rel), .nv_ack(nv_ack));
  pms_nv_model mem (.clk(clk), .rst(rst), .nv_req(nv_req), .lat(lat), .nv_ack(nv_ack));
  always #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic wb(input logic [2:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [2:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_rd.push_back({m, v});
    wb(a, 1'b0, 32'h0);
  endtask : rd
  task automatic cmd(input logic [3:0] op, input logic [6:0] arg);
    st = lfsr(st);
    lat <= st[1:0];
    wb(`PMS_IX_CMD, 1'b1, {21'h0, arg, op});
  endtask : cmd
  task automatic xn(input logic [21:0] m, input logic [21:0] v);
    exp_nv.push_back({m, v});
  endtask : xn
  task automatic ld(input logic [6:0] loc);
    xn(22'h3FFFE0, {3'h1, loc, 7'h63, 5'h0});
  endtask : ld
  task automatic idle();
    int n;
    int q;
    n = 0;
    q = 0;
    while (q < 4 && n < 1000) begin
      @(posedge clk);
      n++;
      q = nv_req ? 0 : q + 1;
    end
  endtask : idle
  task automatic fill(input logic busy_chk);
    for (int i = 1; i <= 52; i++) begin
      xn(22'h3FFFE0, {3'h2, 7'h61, (i <= 50) ? 7'(i) : (i == 51 ? 7'h60 : 7'h63), 5'h0});
    end
    if (busy_chk) rd(3'h2, 32'h0180, 32'h0080);
    idle();
  endtask : fill
  // Results are matched in order; an answer with nothing noted is a mismatch
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      re = exp_rd.size() > 0 ? exp_rd.pop_front() : 64'hFFFFFFFF;
      check(wb_dat_o & re[63:32], re[31:0]);
    end
    if (nv_req === 1'b1 && nv_ack === 1'b1) begin
      nv_seen++;
      ne = exp_nv.size() > 0 ? exp_nv.pop_front() : 44'hFFFFFFFFFFF;
      check({10'h0, {nv_op, nv_src, nv_dst, nv_param, nv_rel} & ne[43:22]}, {10'h0, ne[21:0]});
    end
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    int n;
    logic [6:0] loc;
    {clk, wb_cyc_i, wb_stb_i, wb_we_i, sweep_active, lat, nv_seen, n_fail, check_count} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rst = 1'b1;
    st = 16'h19BE;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb_sel_i <= 4'hF;
    rd(3'h1, 32'hFFFFFFFF, 32'h0);
    rd(3'h3, 32'hFFFFFFFF, 32'h0);
    rd(3'h5, 32'hFFFFFFFF, 32'h0);
    cmd(`PMS_C_PRECALL, 7'h01);
    xn(22'h3FF01F, {3'h4, 7'h61, 7'h0, 4'h1, 1'b1});
    idle();
    cmd(`PMS_C_PSTORE, 7'h00);
    xn(22'h38001F, {3'h3, 14'h0, 4'h0, 1'b1});
    idle();
    cmd(`PMS_C_PRECALL, 7'h03);
    xn(22'h3FF01F, {3'h4, 7'h60, 7'h0, 4'h3, 1'b0});
    idle();
    loc = 7'(st % 50) + 7'h01;
    cmd(`PMS_C_STORE, loc);
    xn(22'h380FE0, {3'h0, 7'h0, loc, 5'h0});
    idle();
    rd(3'h2, 32'h7F, {25'h0, loc});
    cmd(`PMS_C_RECALL, 7'h32);
    ld(7'h32);
    idle();
    cmd(`PMS_C_SEQ_UP, 7'h0);
    ld(7'h01);
    idle();
    cmd(`PMS_C_SEQ_DN, 7'h0);
    ld(7'h32);
    idle();
    wb(3'h1, 1'b1, 32'h1);
    cmd(`PMS_C_STORE, 7'h05);
    rd(3'h2, 32'h4000, 32'h4000);
    cmd(`PMS_C_PSTORE, 7'h02);
    cmd(`PMS_C_RECALL, 7'h05);
    ld(7'h05);
    idle();
    rd(3'h1, 32'hFFFFFFFF, 32'h1);
    wb(3'h1, 1'b1, 32'h0);
    sweep_active <= 1'b1;
    repeat (6) @(posedge clk);
    cmd(`PMS_C_SEQ_UP, 7'h0);
    cmd(`PMS_C_SEQ_DN, 7'h0);
    rd(3'h2, 32'hC07F, 32'hC005);
    sweep_active <= 1'b0;
    repeat (6) @(posedge clk);
    cmd(`PMS_C_DIV_SHOW, 7'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h1);
    rd(3'h2, 32'h0200, 32'h0200);
    cmd(`PMS_C_DIV_DIGIT, 7'h4);
    cmd(`PMS_C_DIV_SKIP, 7'h0);
    rd(3'h3, 32'hFFFFFFFF, 32'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h7);
    cmd(`PMS_C_DIV_DIGIT, 7'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h7);
    rd(3'h3, 32'hFFFFFFFF, 32'h0E070000);
    rd(3'h2, 32'h2000, 32'h2000);
    for (int i = 0; i < 5; i++) begin
      cmd(`PMS_C_RECALL, pa[i]);
      ld(pa[i]);
      idle();
      cmd(pu[i] ? `PMS_C_SEQ_UP : `PMS_C_SEQ_DN, 7'h0);
      ld(pe[i]);
      idle();
    end
    cmd(`PMS_C_DIV_SHOW, 7'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h6);
    rd(3'h2, 32'h4200, 32'h4000);
    cmd(`PMS_C_DIV_SHOW, 7'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h5);
    cmd(`PMS_C_DIV_DIGIT, 7'h1);
    rd(3'h2, 32'h4200, 32'h4000);
    cmd(`PMS_C_DIV_SHOW, 7'h0);
    cmd(`PMS_C_DIV_DIGIT, 7'h2);
    cmd(`PMS_C_KEY_OTHER, 7'h0);
    rd(3'h2, 32'h0200, 32'h0);
    rd(3'h3, 32'hFFFFFFFF, 32'h0E070000);
    cmd(`PMS_C_RECALL, 7'h30);
    ld(7'h30);
    idle();
    // Prompt answers keep the release of the held key ahead of the next repeat
    lat <= 2'h0;
    n = nv_seen + 3;
    ld(7'h31);
    ld(7'h32);
    ld(7'h0E);
    wb(3'h1, 1'b1, 32'h2);
    for (int k = 0; k < 100 && nv_seen < n; k++) @(negedge clk);
    wb(3'h1, 1'b1, 32'h0);
    idle();
    n = nv_seen + 3;
    ld(7'h32);
    ld(7'h31);
    ld(7'h30);
    wb(3'h1, 1'b1, 32'h4);
    for (int k = 0; k < 100 && nv_seen < n; k++) @(negedge clk);
    wb(3'h1, 1'b1, 32'h0);
    idle();
    cmd(`PMS_C_RESET_FP, 7'h0);
    repeat (25) @(posedge clk);
    cmd(`PMS_C_KEY_STORE, 7'h0);
    cmd(`PMS_C_RESET_FP, 7'h0);
    cmd(`PMS_C_KEY_OTHER, 7'h0);
    idle();
    cmd(`PMS_C_RESET_FP, 7'h0);
    cmd(`PMS_C_KEY_STORE, 7'h0);
    fill(1'b0);
    rd(3'h3, 32'hFFFFFFFF, 32'h0E070000);
    cmd(`PMS_C_PRECALL, 7'h01);
    xn(22'h3FF01F, {3'h4, 7'h61, 7'h0, 4'h1, 1'b1});
    idle();
    cmd(`PMS_C_RESET_RMT, 7'h0);
    fill(1'b1);
    check(32'(exp_nv.size()), 32'h0);
    results();
  end
endmodule : pms_sequencer_test
